// [hdl/phase_servo_pkg.sv]
// ****************************************************************
// Shared constants and types for the phase and servo clock link
// ****************************************************************
package phase_servo_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  // Half a phase period at the default 9.04 kHz phase rate.
  localparam int CLK_PERIOD_NS  = 20;
  localparam int PHASE_HALF_NS  = 55310;
  // A half period is a longest time, so the division rounds down.
  localparam int PHASE_HALF_CYC = PHASE_HALF_NS / CLK_PERIOD_NS;
  localparam int DIV_W          = 12;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PHASE_HALF_CYC - 1);

  // Default of four phase cycles per servo cycle.
  localparam int SERVO_W = 2;
  localparam logic [SERVO_W-1:0] SERVO_LAST  = 2'h3;
  localparam logic [SERVO_W-1:0] SERVO_FIRST = 2'h0;

  // ****************************************************************
  // Data paths
  // ****************************************************************
  localparam int NUM_CH = 2;
  localparam int CH_W   = 1;
  localparam int DATA_W = 16;
  localparam int IDX_W  = 2;
  localparam logic [CH_W-1:0]  CH_LAST = 1'h1;
  localparam logic [IDX_W-1:0] SER_IDX = 2'h2;

  typedef logic [DATA_W-1:0] word_type;
  typedef logic [IDX_W-1:0]  idx_type;
  typedef logic [CH_W-1:0]   ch_type;

  // Serial feedback strobe points.
  typedef enum logic [1:0] {
    STROBE_PHASE_RISE = 2'h0,
    STROBE_PHASE_FALL = 2'h1,
    STROBE_SERVO_RISE = 2'h2,
    STROBE_SERVO_FALL = 2'h3
  } strobe_sel_type;

  // ****************************************************************
  // Host-side tables
  // ****************************************************************
  localparam int NUM_ENTRIES = 8;
  localparam int ENT_W       = 3;
  localparam int TYPE_W      = 3;
  localparam int CONV_W      = 4;
  localparam int RTI_W       = 8;
  localparam logic [TYPE_W-1:0] TYPE_END  = 3'h0;
  localparam logic [ENT_W-1:0]  ENT_LAST  = 3'h7;

endpackage

// [hdl/servo_link_if.sv]
`timescale 1ns/10ps
// ****************************************************************
// Link between the servo interface logic and the processor side
// ****************************************************************
interface servo_link_if;
  import phase_servo_pkg::*;

  logic     phase_clk;  // Phase clock level.
  logic     servo_clk;  // Servo clock level.
  logic     irq;        // One-cycle pulse at each falling phase edge.
  logic     rd_en;      // Read request.
  idx_type  rd_idx;     // Holding register index to read.
  word_type rd_data;    // Read answer.
  logic     rd_valid;   // Read answer valid, one cycle.
  logic     wr_en;      // Command register write.
  idx_type  wr_idx;     // Command register index.
  word_type wr_data;    // Command value.

  modport dev (
    output phase_clk, servo_clk, irq, rd_data, rd_valid,
    input  rd_en, rd_idx, wr_en, wr_idx, wr_data
  );

  modport cpu (
    input  phase_clk, servo_clk, irq, rd_data, rd_valid,
    output rd_en, rd_idx, wr_en, wr_idx, wr_data
  );

endinterface

// [hdl/servo_sync_dev.sv]
`timescale 1ns/10ps
// How it works
// [R1] Latch encoder counts on falling phase or servo edge.
// [R2] Same falling edge raises the processor interrupt.
// [R3] Serial strobe on prior rising edge, latched at interrupt.
// [R4] Serial strobe selectable: falling phase, either servo edge.
// [R5] Commands reach outputs only at rising phase edge.
// [R6] Late command writes wait for the next rising edge.
// [R7] Processor runs phase tasks, writes commands when ready.
// [R8] Servo tasks follow phase tasks while servo low.
// [R9] Commutated servo output kept internally for phase use.
// [R10] Late commutated servo result used one cycle later.
// [R11] Early servo command leaves after one eighth servo cycle.
// [R12] Real-time tick every period plus one servo interrupts.
// [R13] Conversion walk from first index until type zero.
// [R14] Servo clock is phase clock divided by integer.
module servo_sync_dev
  import phase_servo_pkg::*;
(
  input  logic                          clk_sys,     // System clock, 50 MHz.
  input  logic                          rst_b,       // Asynchronous reset, active low.
  input  logic [NUM_CH-1:0][DATA_W-1:0] enc_count,   // Live encoder counts.
  input  logic [NUM_CH-1:0]             fb_on_servo, // Latch channel on servo edge only.
  input  strobe_sel_type                strobe_sel,  // Serial feedback strobe point.
  output logic                          ser_strobe,  // Serial feedback strobe pulse.
  input  logic                          ser_valid,   // Serial word received.
  input  word_type                      ser_data,    // Serial word.
  output logic [NUM_CH-1:0][DATA_W-1:0] cmd_out,     // Commands to output circuitry.
  output logic                          cmd_load,    // Pulse when cmd_out updates.
  servo_link_if.dev                     bus          // Processor side of the link.
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    // Dividers and clock levels.
    logic [DIV_W-1:0]              div_cnt;
    logic                          phase_clk;
    logic [SERVO_W-1:0]            phase_num;
    logic                          servo_clk;
    // One-cycle pulses.
    logic                          irq;
    logic                          ser_strobe;
    logic                          cmd_load;
    // Feedback holding registers.
    logic [NUM_CH-1:0][DATA_W-1:0] fb_hold;
    word_type                      ser_shadow;
    word_type                      ser_hold;
    // Command path.
    logic [NUM_CH-1:0][DATA_W-1:0] cmd_pending;
    logic [NUM_CH-1:0][DATA_W-1:0] cmd_out;
    // Read port.
    word_type                      rd_data;
    logic                          rd_valid;
  } dev_state_type;

  dev_state_type s;
  dev_state_type next_s;

  // Edge events of the phase clock, valid for one cycle.
  logic rise;
  logic fall;

  // Servo edges, a subset of the falling phase edges.
  logic servo_rise;
  logic servo_fall;

  // ****************************************************************
  // Clock edges
  // ****************************************************************
  // The phase clock toggles every half period; the servo clock only
  // moves on a falling phase edge, so every servo edge coincides with
  // a phase edge and no servo edge can arrive between two phase edges.
  always_comb begin
    rise       = 1'b0;
    fall       = 1'b0;
    servo_rise = 1'b0;
    servo_fall = 1'b0;

    if (s.div_cnt == DIV_LAST) begin
      rise = ~s.phase_clk;
      fall = s.phase_clk;
    end

    servo_fall = fall && (s.phase_num == SERVO_LAST);  // R14
    servo_rise = fall && (s.phase_num == SERVO_FIRST); // R14
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  // One process computes the whole next state from the edge events.
  always_comb begin
    next_s            = s;
    next_s.irq        = 1'b0;
    next_s.ser_strobe = 1'b0;
    next_s.cmd_load   = 1'b0;
    next_s.rd_valid   = 1'b0;

    // Phase clock divider and servo divider.
    // Both phase halves last the same count.
    if (s.div_cnt == DIV_LAST) begin
      next_s.div_cnt   = '0;
      next_s.phase_clk = ~s.phase_clk;
    end else begin
      next_s.div_cnt = s.div_cnt + 1'b1;
    end
    if (fall) begin
      next_s.phase_num = s.phase_num + 1'b1; // R14
    end
    if (servo_fall) begin
      next_s.servo_clk = 1'b0;
    end else if (servo_rise) begin
      next_s.servo_clk = 1'b1;
    end

    // The interrupt leaves on the very edge that latches feedback, so
    // the processor never reads a holding register mid-update.
    next_s.irq = fall; // R2

    // Direct feedback: each channel latches on a falling phase edge, or
    // only on the falling servo edge when it is set to servo rate.
    // A servo-rate channel skips the other falls.
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (fall && (!fb_on_servo[ch] || servo_fall)) begin
        next_s.fb_hold[ch] = enc_count[ch]; // R1
      end
    end

    // Serial feedback strobe point.
    // Only the selected strobe point is live.
    unique case (strobe_sel)
      STROBE_PHASE_RISE: next_s.ser_strobe = rise;       // R3
      STROBE_PHASE_FALL: next_s.ser_strobe = fall;       // R4
      STROBE_SERVO_RISE: next_s.ser_strobe = servo_rise; // R4
      STROBE_SERVO_FALL: next_s.ser_strobe = servo_fall; // R4
    endcase

    // Received serial words wait in a shadow register and become
    // readable only at the interrupt edge. A word that arrives after
    // the interrupt edge simply waits for the following one.
    // A late word never tears the one being read.
    if (ser_valid) begin
      next_s.ser_shadow = ser_data;
    end
    if (fall) begin
      next_s.ser_hold = s.ser_shadow; // R3
    end

    // Commands move to the output circuitry on the rising phase edge.
    // With four phase cycles a servo cycle, a servo command written
    // before the first rising edge leaves one eighth of a cycle late.
    if (rise) begin
      next_s.cmd_out  = s.cmd_pending; // R5 R11
      next_s.cmd_load = 1'b1;          // R5
    end

    // A write only fills the pending copy; it is applied at the next
    // rising edge, even one written in the cycle of a rising edge.
    // Writes to indices two and three are dropped.
    if (bus.wr_en && (bus.wr_idx < SER_IDX)) begin
      next_s.cmd_pending[bus.wr_idx[CH_W-1:0]] = bus.wr_data; // R6
    end

    // Holding register reads answer one cycle later. Unused indices
    // read as zero.
    if (bus.rd_en) begin
      next_s.rd_valid = 1'b1;
      if (bus.rd_idx < SER_IDX) begin
        next_s.rd_data = s.fb_hold[bus.rd_idx[CH_W-1:0]];
      end else if (bus.rd_idx == SER_IDX) begin
        next_s.rd_data = s.ser_hold;
      end else begin
        next_s.rd_data = '0;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Both derived clocks start low with the dividers cleared.
  // The first phase edge is thus a rise.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output is taken straight from the state register.
  assign ser_strobe    = s.ser_strobe;
  assign cmd_out       = s.cmd_out;
  assign cmd_load      = s.cmd_load;

  // Link outputs; all registered, so free of glitches.
  assign bus.phase_clk = s.phase_clk;
  assign bus.servo_clk = s.servo_clk;
  assign bus.irq       = s.irq;
  assign bus.rd_data   = s.rd_data;
  assign bus.rd_valid  = s.rd_valid;

endmodule

// [hdl/servo_sync_cpu.sv]
`timescale 1ns/10ps
module servo_sync_cpu
  import phase_servo_pkg::*;
(
  input  logic                               clk_sys,                // System clock, 50 MHz.
  input  logic                               rst_b,                  // Asynchronous reset, low.
  input  logic [NUM_CH-1:0]                  commutated,             // Channel is commutated.
  input  logic [NUM_CH-1:0][DATA_W-1:0]      servo_target,           // Servo target per channel.
  input  logic [ENT_W-1:0]                   first_conversion_index, // First table entry.
  input  logic [NUM_ENTRIES-1:0][TYPE_W-1:0] conversion_entry_type,  // Entry type fields.
  input  logic [RTI_W-1:0]                   rti_period_minus_one,   // Real-time period less one.
  output logic                               rti_tick,               // Real-time task pulse.
  output logic [CONV_W-1:0]                  conv_count,             // Entries walked after last phase task.
  servo_link_if.cpu                          bus                     // Link to the device.
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0] {
    IDLE  = 3'h0,
    READ  = 3'h1,
    PHASE = 3'h3,
    CONV  = 3'h2,
    SERVO = 3'h6,
    RTI   = 3'h7
  } task_type;

  typedef struct packed {
    task_type                      state;
    logic                          irq_pend;
    logic                          servo_low;
    idx_type                       rd_ptr;
    idx_type                       cap_ptr;
    ch_type                        ch;
    logic [ENT_W-1:0]              ent;
    logic [NUM_CH:0][DATA_W-1:0]   fb;
    logic [NUM_CH-1:0][DATA_W-1:0] servo_mem;
    logic [NUM_CH-1:0][DATA_W-1:0] used_mem;
    logic [CONV_W-1:0]             conv_count;
    logic [RTI_W-1:0]              rti_cnt;
    logic                          rti_tick;
    logic                          rd_en;
    idx_type                       rd_idx;
    logic                          wr_en;
    idx_type                       wr_idx;
    word_type                      wr_data;
  } cpu_state_type;

  cpu_state_type s;
  cpu_state_type next_s;

  // ****************************************************************
  // Task sequencer
  // ****************************************************************
  // Tasks run one at a time, like a single interrupt core: an
  // interrupt that lands while busy is remembered and served next.
  always_comb begin
    next_s          = s;
    next_s.rd_en    = 1'b0;
    next_s.wr_en    = 1'b0;
    next_s.rti_tick = 1'b0;

    // The servo level and the stored servo output are both taken at the
    // interrupt edge: a servo result not stored by then waits a cycle.
    if (bus.irq) begin
      next_s.irq_pend  = 1'b1;
      next_s.servo_low = ~bus.servo_clk; // R8
      next_s.used_mem  = s.servo_mem;    // R10
    end

    unique case (s.state)
      IDLE: begin
        if (s.irq_pend) begin
          next_s.irq_pend = bus.irq;
          next_s.rd_ptr   = '0;
          next_s.cap_ptr  = '0;
          next_s.state    = READ; // R7
        end
      end
      READ: begin
        if (s.rd_ptr <= SER_IDX) begin
          next_s.rd_en  = 1'b1;
          next_s.rd_idx = s.rd_ptr;
          next_s.rd_ptr = s.rd_ptr + 1'b1;
        end
        if (bus.rd_valid) begin
          next_s.fb[s.cap_ptr] = bus.rd_data;
          next_s.cap_ptr       = s.cap_ptr + 1'b1;
          if (s.cap_ptr == SER_IDX) begin
            next_s.ch    = '0;
            next_s.state = PHASE;
          end
        end
      end
      PHASE: begin
        // A toy commutation adds feedback to the stored servo output.
        next_s.wr_en   = commutated[s.ch];                   // R7
        next_s.wr_idx  = idx_type'(s.ch);
        next_s.wr_data = s.used_mem[s.ch] + s.fb[s.ch];     // R9
        next_s.ch      = s.ch + 1'b1;
        if (s.ch == CH_LAST) begin
          next_s.ent        = first_conversion_index;
          next_s.conv_count = '0;
          next_s.state      = s.servo_low ? CONV : IDLE;     // R8
        end
      end
      CONV: begin
        if (conversion_entry_type[s.ent] == TYPE_END) begin
          next_s.ch    = '0;
          next_s.state = SERVO;                              // R13
        end else begin
          next_s.conv_count = s.conv_count + 1'b1;
          next_s.ent        = s.ent + 1'b1;                  // R13
          if (s.ent == ENT_LAST) begin
            next_s.ch    = '0;
            next_s.state = SERVO;
          end
        end
      end
      SERVO: begin
        // Uncommutated outputs go straight to the device so they leave
        // at the first rising phase edge; commutated ones stay here.
        if (commutated[s.ch]) begin
          next_s.servo_mem[s.ch] = servo_target[s.ch] - s.fb[s.ch]; // R9
        end else begin
          next_s.wr_en   = 1'b1;                             // R11
          next_s.wr_idx  = idx_type'(s.ch);
          next_s.wr_data = servo_target[s.ch] - s.fb[s.ch];
        end
        next_s.ch = s.ch + 1'b1;
        if (s.ch == CH_LAST) begin
          if (s.rti_cnt == rti_period_minus_one) begin
            next_s.rti_cnt = '0;
            next_s.state   = RTI;                            // R12
          end else begin
            next_s.rti_cnt = s.rti_cnt + 1'b1;
            next_s.state   = IDLE;
          end
        end
      end
      RTI: begin
        next_s.rti_tick = 1'b1;                              // R12
        next_s.state    = IDLE;
      end
      default: begin
        next_s.state = IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register and outputs
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rti_tick    = s.rti_tick;
  assign conv_count  = s.conv_count;
  assign bus.rd_en   = s.rd_en;
  assign bus.rd_idx  = s.rd_idx;
  assign bus.wr_en   = s.wr_en;
  assign bus.wr_idx  = s.wr_idx;
  assign bus.wr_data = s.wr_data;

endmodule

// [tb/servo_link_props.sv]
`timescale 1ns/10ps
// ****************************************************************
// Checker for the link between the two ends
// ****************************************************************
module servo_link_props
  import phase_servo_pkg::*;
(
  input logic     clk_sys,   // System clock.
  input logic     rst_b,     // Asynchronous reset, active low.
  input logic     phase_clk, // Phase clock level.
  input logic     servo_clk, // Servo clock level.
  input logic     irq,       // Phase interrupt pulse.
  input logic     rd_en,     // Read request.
  input idx_type  rd_idx,    // Read index.
  input word_type rd_data,   // Read answer.
  input logic     rd_valid,  // Read answer valid.
  input logic     wr_en,     // Command write.
  input idx_type  wr_idx,    // Command index.
  input word_type wr_data    // Command value.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  logic [DIV_W-1:0] run;
  logic             last_ph;

  // Cycles since the phase clock last moved, so a half period can be measured.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run     <= '0;
      last_ph <= 1'b0;
    end else begin
      last_ph <= phase_clk;
      run     <= (phase_clk != last_ph) ? '0 : run + 1'b1;
    end
  end

  AST_IRQ_AT_FALL: assert property ($fell(phase_clk) |-> irq)
    else $error("interrupt missing at phase fall");
  AST_IRQ_ONLY_FALL: assert property (irq |-> $fell(phase_clk))
    else $error("interrupt away from phase fall");
  AST_SERVO_WITH_PHASE: assert property ($changed(servo_clk) |-> $fell(phase_clk))
    else $error("servo edge without phase fall");
  AST_READ_ANSWER: assert property (rd_en |=> rd_valid)
    else $error("read not answered next cycle");
  AST_READ_CAUSE: assert property (rd_valid |-> $past(rd_en))
    else $error("read answer without request");
  AST_SPARE_READ_ZERO: assert property (rd_en && rd_idx == 2'h3 |=> rd_data == '0)
    else $error("spare index did not read zero");
  AST_READ_SEQ: assert property (irq |-> ##[1:8] (rd_en && rd_idx == 2'h0)
    ##1 (rd_en && rd_idx == 2'h1) ##1 (rd_en && rd_idx == SER_IDX))
    else $error("feedback reads did not follow interrupt");
  AST_WR_CHANNEL: assert property (wr_en |-> wr_idx < idx_type'(NUM_CH))
    else $error("command write to missing channel");
  AST_PHASE_HALF: assert property ((phase_clk != last_ph) |->
    (run >= DIV_W'(PHASE_HALF_CYC - 2)) && (run <= DIV_W'(PHASE_HALF_CYC)))
    else $error("phase half period wrong");
  AST_PHASE_RUNS: assert property (run <= DIV_W'(PHASE_HALF_CYC + 1))
    else $error("phase clock stalled");

  COV_SERVO_FALL: cover property ($fell(servo_clk));
  COV_SER_READ: cover property (rd_valid && $past(rd_idx) == SER_IDX);
  COV_WRITE: cover property (wr_en && wr_data != '0);
endmodule

// [tb/phase_servo_clock_sync_bench.sv]
`timescale 1ns/10ps
// ****************************************************************
// Bench for both ends of the phase and servo link
// ****************************************************************
module phase_servo_clock_sync_bench;
  import phase_servo_pkg::*;

  localparam int LIMIT = 80000;
  localparam int WAIT  = 23000;

  logic                               clk_sys;
  logic                               rst_b;
  logic [NUM_CH-1:0][DATA_W-1:0]      enc_count;
  logic [NUM_CH-1:0]                  fb_on_servo;
  strobe_sel_type                     strobe_sel;
  logic                               ser_strobe;
  logic                               ser_valid;
  word_type                           ser_data;
  logic [NUM_CH-1:0][DATA_W-1:0]      cmd_out;
  logic                               cmd_load;
  logic [NUM_CH-1:0]                  commutated;
  logic [NUM_CH-1:0][DATA_W-1:0]      servo_target;
  logic [ENT_W-1:0]                   first_conversion_index;
  logic [NUM_ENTRIES-1:0][TYPE_W-1:0] conversion_entry_type;
  logic [RTI_W-1:0]                   rti_period_minus_one;
  logic                               rti_tick;
  logic [CONV_W-1:0]                  conv_count;
  int                                 n_fail;
  int                                 n_tests;
  int                                 n_servo;
  int                                 n_rti;
  int                                 cyc;
  logic [NUM_CH-1:0][DATA_W-1:0]      prev_cmd;
  logic                               prev_ph;
  logic                               prev_sv;
  logic [3:0]                         edges;

  servo_link_if i_servo_link_if ();

  servo_sync_dev i_servo_sync_dev (
    .clk_sys(clk_sys), .rst_b(rst_b), .enc_count(enc_count), .fb_on_servo(fb_on_servo),
    .strobe_sel(strobe_sel), .ser_strobe(ser_strobe), .ser_valid(ser_valid),
    .ser_data(ser_data), .cmd_out(cmd_out), .cmd_load(cmd_load), .bus(i_servo_link_if)
  );

  servo_sync_cpu i_servo_sync_cpu (
    .clk_sys(clk_sys), .rst_b(rst_b), .commutated(commutated), .servo_target(servo_target),
    .first_conversion_index(first_conversion_index),
    .conversion_entry_type(conversion_entry_type),
    .rti_period_minus_one(rti_period_minus_one), .rti_tick(rti_tick),
    .conv_count(conv_count), .bus(i_servo_link_if)
  );

  servo_link_props i_servo_link_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .phase_clk(i_servo_link_if.phase_clk),
    .servo_clk(i_servo_link_if.servo_clk), .irq(i_servo_link_if.irq),
    .rd_en(i_servo_link_if.rd_en), .rd_idx(i_servo_link_if.rd_idx),
    .rd_data(i_servo_link_if.rd_data), .rd_valid(i_servo_link_if.rd_valid),
    .wr_en(i_servo_link_if.wr_en), .wr_idx(i_servo_link_if.wr_idx),
    .wr_data(i_servo_link_if.wr_data)
  );

  // The clock toggles every half period of 10 ns.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] want, input string msg);
    n_tests++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, msg, seen, want);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Sample 2 ns after the edge, once the monitor below has settled its flags.
  task automatic tick;
    @(posedge clk_sys);
    #2;
  endtask

  // Watches outputs each cycle; a command may only move at a phase rise.
  always @(posedge clk_sys) begin
    #1;
    edges = {i_servo_link_if.phase_clk & ~prev_ph, prev_ph & ~i_servo_link_if.phase_clk,
             i_servo_link_if.servo_clk & ~prev_sv, prev_sv & ~i_servo_link_if.servo_clk};
    if (rst_b === 1'b1) begin
      if (cmd_out !== prev_cmd) check(cmd_load, 1'b1, "command moved without load");
      if (cmd_load === 1'b1) check(edges[3], 1'b1, "load away from phase rise");
      if (i_servo_link_if.irq === 1'b1 && i_servo_link_if.servo_clk === 1'b0) n_servo++;
      if (rti_tick === 1'b1) n_rti++;
      cyc++;
      if (cyc == LIMIT) begin
        n_fail++;
        complete_run();
      end
    end
    prev_cmd = cmd_out;
    prev_ph  = i_servo_link_if.phase_clk;
    prev_sv  = i_servo_link_if.servo_clk;
  end

  task automatic wait_irq(input logic low_only);
    for (int i = 0; i < WAIT; i++) begin
      tick();
      if (i_servo_link_if.irq === 1'b1 &&
          (!low_only || i_servo_link_if.servo_clk === 1'b0)) return;
    end
    check(1'b0, 1'b1, "no phase interrupt");
  endtask

  task automatic wait_load(output int n);
    n = 0;
    while (cmd_load !== 1'b1 && n < WAIT) begin
      tick();
      n++;
    end
  endtask

  // Looks at the current cycle first, so a request just after the interrupt is seen.
  task automatic get_read(input idx_type idx, output word_type data);
    data = '0;
    for (int i = 0; i < 16; i++) begin
      if (i_servo_link_if.rd_en === 1'b1 && i_servo_link_if.rd_idx === idx) begin
        tick();
        data = i_servo_link_if.rd_data;
        return;
      end
      tick();
    end
    check(1'b0, 1'b1, "read not issued");
  endtask

  // Counts and serial word must be the values present at the phase fall.
  task automatic feedback_latch;
    word_type d;
    @(posedge clk_sys);
    enc_count[0] <= 16'h1234;
    ser_data     <= 16'h0a5c;
    ser_valid    <= 1'b1;
    @(posedge clk_sys);
    ser_valid <= 1'b0;
    ser_data  <= 16'hf5a3;
    wait_irq(1'b0);
    @(posedge clk_sys);
    enc_count[0] <= 16'h4321;
    enc_count[1] <= 16'h0020;
    fb_on_servo  <= 2'h2;
    #2;
    get_read(2'h0, d);
    check(d, 16'h1234, "count latched at fall");
    get_read(SER_IDX, d);
    check(d, 16'h0a5c, "serial word latched at fall");
  endtask

  // The servo cycle drives channel 0 directly and feeds channel 1 through memory.
  task automatic servo_timing;
    int       n;
    word_type want0;
    want0 = 16'h0500 - 16'h4321;
    wait_irq(1'b1);
    wait_load(n);
    check(n, PHASE_HALF_CYC, "servo command delay");
    check(cmd_out[0], want0, "servo command");
    check(cmd_out[1], 16'h0020, "commutated old value");
    check(conv_count, 4'h3, "conversion walk");
    @(posedge clk_sys);
    servo_target[0] <= 16'h0600;
    enc_count[1]    <= 16'h0040;
    #2;
    wait_load(n);
    check(cmd_out[1], 16'h0300, "commutated new value");
    check(cmd_out[0], want0, "no servo task while high");
  endtask

  // Every strobe point is selected once; servo fall comes before servo rise.
  task automatic strobe_points;
    logic [1:0] s;
    logic       hit;
    for (int k = 0; k < 4; k++) begin
      s = 2'(k ^ (k >> 1));
      @(posedge clk_sys);
      strobe_sel <= strobe_sel_type'(s);
      hit = 1'b0;
      for (int i = 0; i < WAIT && !hit; i++) begin
        tick();
        hit = (ser_strobe === 1'b1);
      end
      check(hit, 1'b1, "strobe seen");
      check(edges[3 - s], 1'b1, "strobe at chosen edge");
    end
  endtask

  // Main sequence: reset for 20 cycles, then the scenarios in turn.
  initial begin
    n_fail                 = 0;
    n_tests                = 0;
    n_servo                = 0;
    n_rti                  = 0;
    cyc                    = 0;
    rst_b                  = 1'b0;
    enc_count              = {16'h0010, 16'h0000};
    fb_on_servo            = 2'h0;
    strobe_sel             = STROBE_PHASE_RISE;
    ser_valid              = 1'b0;
    ser_data               = 16'h0000;
    commutated             = 2'h2;
    servo_target           = {16'h0300, 16'h0500};
    first_conversion_index = 3'h2;
    conversion_entry_type  = {3'h4, 3'h4, 3'h0, 3'h3, 3'h2, 3'h1, 3'h4, 3'h4};
    rti_period_minus_one   = 8'h01;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    tick();
    check({cmd_out, cmd_load}, 33'h0, "outputs after reset");
    feedback_latch();
    servo_timing();
    strobe_points();
    check(n_rti, n_servo / 2, "real-time ticks");
    complete_run();
  end
endmodule
